// ==== rtl/pfcg_pkg.sv ====
// package for the pfc pause frame generator: constants and types
package pfcg_pkg;
   localparam int          PFCG_NUM_PRIO      = 8;
   localparam logic [15:0] PFCG_ETHERTYPE     = 16'h8808;
   localparam logic [15:0] PFCG_OPCODE        = 16'h0101;
   localparam logic [15:0] PFCG_PRIO_ENA_VEC  = 16'h00ff;
   localparam logic [47:0] PFCG_DMAC          = 48'h0180c2000001;
   // header 14 bytes, opcode 2, vector 2, eight times 2, pad to 60
   localparam int          PFCG_FRAME_BYTES   = 60;
   localparam int          PFCG_PAYLOAD_END   = 34;
   // one pause quantum is 512 bit times; clocks per quantum is a port setting
   localparam logic [15:0] PFCG_QUANTA_CYC_RST = 16'h0005;
   localparam logic [15:0] PFCG_CNT_RST        = 16'h0000;
   localparam logic [31:0] PFCG_TXCNT_RST      = 32'h0000_0000;
   localparam logic [7:0]  PFCG_VEC_RST        = 8'h00;

   typedef enum logic [1:0] {
      PFCG_IDLE,
      PFCG_SEND,
      PFCG_WAIT
   } pfcg_state_t;
endpackage

// ==== rtl/pfcg_frame_if.sv ====
// interface between the pause decision logic and the frame serialiser
`timescale 1ns/1ps
interface pfcg_frame_if;
   logic        start;
   logic        busy;
   logic        done;
   logic [7:0]  pause_mask;
   logic [15:0] pause_time;
   modport ctrl (output start, output pause_mask, output pause_time,
                 input busy, input done);
   modport ser  (input start, input pause_mask, input pause_time,
                 output busy, output done);
endinterface

// ==== rtl/pfcg_frame_ser.sv ====
// byte serialiser for one pfc pause pdu
`timescale 1ns/1ps
module pfcg_frame_ser
   import pfcg_pkg::*;
(
   input  wire logic        clk,
   input  wire logic        sys_rst,
   input  wire logic [47:0] src_mac,
   pfcg_frame_if.ser        fif,
   output logic [7:0]       tx_data,
   output logic             tx_valid,
   output logic             tx_sof,
   output logic             tx_eof,
   input  wire logic        tx_ready
);
   logic [5:0]  idx_reg;
   logic        act_reg;
   logic [7:0]  mask_reg;
   logic [15:0] time_reg;
   logic [7:0]  byte_sel;
   logic [15:0] prio_time;
   logic [2:0]  prio_idx;
   logic        last_byte;

   assign prio_idx  = 3'((idx_reg - 6'd18) >> 1);
   assign prio_time = mask_reg[prio_idx] ? time_reg : 16'h0000;
   assign last_byte = idx_reg == 6'(PFCG_FRAME_BYTES - 1);

   always_comb begin
      byte_sel = 8'h00;
      if (idx_reg < 6'd6) begin
         byte_sel = PFCG_DMAC[8'(47 - 8 * idx_reg) -: 8];
      end else if (idx_reg < 6'd12) begin
         byte_sel = src_mac[8'(95 - 8 * idx_reg) -: 8];
      end else if (idx_reg == 6'd12) begin
         byte_sel = PFCG_ETHERTYPE[15:8];
      end else if (idx_reg == 6'd13) begin
         byte_sel = PFCG_ETHERTYPE[7:0];
      end else if (idx_reg == 6'd14) begin
         byte_sel = PFCG_OPCODE[15:8];
      end else if (idx_reg == 6'd15) begin
         byte_sel = PFCG_OPCODE[7:0];
      end else if (idx_reg == 6'd16) begin
         byte_sel = PFCG_PRIO_ENA_VEC[15:8];
      end else if (idx_reg == 6'd17) begin
         byte_sel = PFCG_PRIO_ENA_VEC[7:0];
      end else if (idx_reg < 6'(PFCG_PAYLOAD_END)) begin
         byte_sel = idx_reg[0] ? prio_time[7:0] : prio_time[15:8];
      end
   end

   assign fif.busy = act_reg;
   assign fif.done = act_reg && tx_ready && last_byte;
   assign tx_valid = act_reg;
   assign tx_sof   = act_reg && idx_reg == 6'd0;
   assign tx_eof   = act_reg && last_byte;
   assign tx_data  = byte_sel;

   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         act_reg  <= 1'b0;
         idx_reg  <= 6'd0;
         mask_reg <= PFCG_VEC_RST;
         time_reg <= PFCG_CNT_RST;
      end else if (!act_reg) begin
         idx_reg <= 6'd0;
         if (fif.start) begin
            act_reg  <= 1'b1;
            mask_reg <= fif.pause_mask;
            time_reg <= fif.pause_time;
         end
      end else if (tx_ready) begin
         idx_reg <= last_byte ? 6'd0 : idx_reg + 6'd1;
         act_reg <= !last_byte;
      end
   end
endmodule

// ==== rtl/pfcg_top.sv ====
// pfc pause frame generator for one port: decision logic and counters
`timescale 1ns/1ps
module pfcg_top
   import pfcg_pkg::*;
(
   input  wire logic        clk,
   input  wire logic        sys_rst,
   input  wire logic        pfc_tx_ena,
   input  wire logic [7:0]  pfc_prio_ena,
   input  wire logic [7:0]  queue_congestion_vector,
   input  wire logic [15:0] advertised_pause_time,
   input  wire logic [15:0] min_refresh_interval,
   input  wire logic [15:0] quanta_cycles,
   input  wire logic [47:0] src_mac,
   input  wire logic        link_pause_sent,
   output logic [7:0]       congestion_state,
   output logic [31:0]      tx_pause_frame_count,
   output logic [7:0]       tx_data,
   output logic             tx_valid,
   output logic             tx_sof,
   output logic             tx_eof,
   input  wire logic        tx_ready
);
   pfcg_frame_if fif ();

   pfcg_state_t state_reg;
   logic [7:0]  cong_reg;
   logic [7:0]  sent_reg;
   logic [15:0] quanta_reg;
   logic [15:0] elapsed_reg;
   logic        early_reg;
   logic        paused_reg;
   logic [31:0] count_reg;
   logic [7:0]  active_vec;
   logic        new_cong;
   logic        all_clear;
   logic        tick;
   logic        half_due;
   logic        early_due;
   logic        fire;

   function automatic logic [15:0] half_of(input logic [15:0] v);
      return (v >> 1) == 16'h0000 ? 16'h0001 : (v >> 1);
   endfunction

   assign active_vec = cong_reg & pfc_prio_ena;
   assign new_cong   = |(active_vec & ~sent_reg);
   assign all_clear  = active_vec == 8'h00;
   assign tick       = quanta_reg + 16'h0001 >= quanta_cycles;
   assign half_due   = elapsed_reg >= half_of(advertised_pause_time);
   assign early_due  = early_reg && elapsed_reg >= min_refresh_interval;

   assign fire = pfc_tx_ena && state_reg != PFCG_SEND && !fif.busy &&
                 ((state_reg == PFCG_IDLE && !all_clear) ||
                  (state_reg == PFCG_WAIT &&
                   (all_clear || half_due || early_due)));

   assign fif.start      = fire;
   assign fif.pause_mask = state_reg == PFCG_WAIT && all_clear ? 8'h00 : active_vec;
   assign fif.pause_time = advertised_pause_time;

   assign congestion_state     = cong_reg;
   assign tx_pause_frame_count = count_reg;

   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         cong_reg <= PFCG_VEC_RST;
      end else begin
         cong_reg <= queue_congestion_vector;
      end
   end

   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         state_reg  <= PFCG_IDLE;
         sent_reg   <= PFCG_VEC_RST;
         early_reg  <= 1'b0;
         paused_reg <= 1'b0;
      end else begin
         case (state_reg)
            PFCG_IDLE: begin
               if (fire) begin
                  state_reg  <= PFCG_SEND;
                  sent_reg   <= active_vec;
                  paused_reg <= 1'b1;
                  early_reg  <= 1'b0;
               end
            end
            PFCG_SEND: begin
               if (fif.done) begin
                  state_reg <= paused_reg ? PFCG_WAIT : PFCG_IDLE;
               end
            end
            PFCG_WAIT: begin
               if (!pfc_tx_ena) begin
                  state_reg <= PFCG_IDLE;
                  sent_reg  <= PFCG_VEC_RST;
                  early_reg <= 1'b0;
               end else if (fire) begin
                  state_reg  <= PFCG_SEND;
                  sent_reg   <= active_vec;
                  paused_reg <= !all_clear;
                  early_reg  <= 1'b0;
               end else if (new_cong) begin
                  early_reg <= 1'b1;
               end
            end
            default: begin
               state_reg <= PFCG_IDLE;
            end
         endcase
      end
   end

   // shared refresh timer in pause quanta, restarted by each frame
   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         quanta_reg  <= PFCG_CNT_RST;
         elapsed_reg <= PFCG_CNT_RST;
      end else if (state_reg != PFCG_WAIT) begin
         quanta_reg  <= PFCG_CNT_RST;
         elapsed_reg <= PFCG_CNT_RST;
      end else if (tick) begin
         quanta_reg <= PFCG_CNT_RST;
         if (elapsed_reg != 16'hffff) begin
            elapsed_reg <= elapsed_reg + 16'h0001;
         end
      end else begin
         quanta_reg <= quanta_reg + 16'h0001;
      end
   end

   // counter shared with link level pause frames
   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         count_reg <= PFCG_TXCNT_RST;
      end else begin
         count_reg <= count_reg + 32'(fif.done) + 32'(link_pause_sent);
      end
   end

   pfcg_frame_ser u_ser (
      .clk      (clk),
      .sys_rst  (sys_rst),
      .src_mac  (src_mac),
      .fif      (fif),
      .tx_data  (tx_data),
      .tx_valid (tx_valid),
      .tx_sof   (tx_sof),
      .tx_eof   (tx_eof),
      .tx_ready (tx_ready)
   );
endmodule

// ==== bench/pfcg_sink.sv ====
// link partner model: accepts pause frame bytes, optionally stalling
`timescale 1ns/1ps
module pfcg_sink (
   input  wire logic       clk,
   input  wire logic       slow,
   input  wire logic [7:0] tx_data,
   input  wire logic       tx_valid,
   input  wire logic       tx_eof,
   output logic            tx_ready
);
   logic [7:0] frame [60];
   int         idx = 0;
   logic       rdy = 1'b0;
   assign tx_ready = rdy;
   always @(posedge clk) begin
      if (tx_valid && rdy) begin
         frame[idx] = tx_data;
         idx = tx_eof ? 0 : idx + 1;
      end
      rdy <= ~(slow & rdy);
   end
endmodule

// ==== bench/pfcg_top_asserts.sv ====
// assertion checker on the pause generator ports
`timescale 1ns/1ps
module pfcg_top_asserts
   import pfcg_pkg::*;
(
   input wire logic        clk,
   input wire logic        sys_rst,
   input wire logic        pfc_tx_ena,
   input wire logic [7:0]  pfc_prio_ena,
   input wire logic        link_pause_sent,
   input wire logic [7:0]  congestion_state,
   input wire logic [31:0] tx_pause_frame_count,
   input wire logic [7:0]  tx_data,
   input wire logic        tx_valid,
   input wire logic        tx_sof,
   input wire logic        tx_eof,
   input wire logic        tx_ready
);
   logic [5:0] bc;
   wire        acc  = tx_valid && tx_ready;
   wire        last = acc && tx_eof;
   wire [5:0]  boff = bc - 6'h12;
   // index of the byte on the wire
   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst)
         bc <= 6'h00;
      else if (acc)
         bc <= tx_eof ? 6'h00 : bc + 6'h01;
   end
   default clocking @(posedge clk); endclocking
   default disable iff (sys_rst);
   first_start_a: assert property (tx_pause_frame_count == 32'h0 && !tx_valid && pfc_tx_ena
      && |(congestion_state & pfc_prio_ena) |=> tx_valid && tx_sof) else $error("no start");
   frame_len_a: assert property (tx_valid |-> tx_sof == (bc == 6'h00)
      && tx_eof == (bc == 6'h3b)) else $error("bad length");
   ctrl_fields_a: assert property (tx_valid && bc inside {[6'h0e:6'h11]}
      |-> tx_data == (bc[1] ? 8'h01 : {8{bc[0]}})) else $error("bad opcode");
   off_prio_a: assert property (tx_valid && bc >= 6'h12 && bc < 6'h22
      && !pfc_prio_ena[boff[3:1]] |-> tx_data == 8'h00) else $error("off prio time");
   pad_zero_a: assert property (tx_valid && bc >= 6'h22 |-> tx_data == 8'h00)
      else $error("bad pad");
   byte_hold_a: assert property (tx_valid && !tx_ready |=> tx_valid && $stable(tx_data))
      else $error("byte dropped");
   count_add_a: assert property (last || link_pause_sent |=> tx_pause_frame_count ==
      $past(tx_pause_frame_count) + 32'($past(last)) + 32'($past(link_pause_sent)))
      else $error("bad count step");
   count_hold_a: assert property (!last && !link_pause_sent |=> $stable(tx_pause_frame_count))
      else $error("count moved");
   cover property (last);
   cover property (tx_valid && !tx_ready);
   cover property (link_pause_sent);
endmodule
bind pfcg_top pfcg_top_asserts i_pfcg_top_asserts (.clk(clk), .sys_rst(sys_rst),
   .pfc_tx_ena(pfc_tx_ena), .pfc_prio_ena(pfc_prio_ena), .link_pause_sent(link_pause_sent),
   .congestion_state(congestion_state), .tx_pause_frame_count(tx_pause_frame_count),
   .tx_data(tx_data), .tx_valid(tx_valid), .tx_sof(tx_sof), .tx_eof(tx_eof),
   .tx_ready(tx_ready));

// ==== bench/tb.sv ====
// self-checking bench for the pause frame generator
`timescale 1ns/1ps
module tb
   import pfcg_pkg::*;
;
   localparam logic [47:0] SRC = 48'h02aabbccddee;
   localparam logic [15:0] PT  = 16'h0080;
   localparam logic [15:0] QC  = 16'h0002;
   localparam logic [15:0] MRI = 16'h0004;
   logic        clk = 1'b0, sys_rst = 1'b1, ena = 1'b0, lps = 1'b0, slow = 1'b0;
   logic [7:0]  vec = 8'h05, cst, data;
   logic [31:0] cnt, ecnt = 32'h0;
   logic        valid, sof, eof, ready;
   int          n_fail = 0, check_count = 0, g;
   pfcg_top i_pfcg_top (.clk(clk), .sys_rst(sys_rst), .pfc_tx_ena(ena), .pfc_prio_ena(8'hfb),
      .queue_congestion_vector(vec), .advertised_pause_time(PT), .min_refresh_interval(MRI),
      .quanta_cycles(QC), .src_mac(SRC), .link_pause_sent(lps), .congestion_state(cst),
      .tx_pause_frame_count(cnt), .tx_data(data), .tx_valid(valid), .tx_sof(sof),
      .tx_eof(eof), .tx_ready(ready));
   pfcg_sink i_pfcg_sink (.clk(clk), .slow(slow), .tx_data(data), .tx_valid(valid),
      .tx_eof(eof), .tx_ready(ready));
   initial forever #5 clk = ~clk;
   task automatic stop_test;
      $display("checks %0d mismatches %0d", check_count, n_fail);
      if (n_fail == 0 && check_count > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      check_count++;
      if (got !== exp) begin
         n_fail++;
         $display("FAIL %0t got %h exp %h", $time, got, exp);
      end
   endtask
   task automatic cyc(input int n);
      repeat (n) @(posedge clk);
      #1;
   endtask
   // g counts idle cycles before the frame starts
   task automatic next_frame;
      g = 0;
      while (!sof && g < 400) begin
         cyc(1);
         g++;
      end
      for (int k = 0; k < 300 && !(valid && ready && eof); k++)
         cyc(1);
      if (!(valid && ready && eof)) begin
         n_fail++;
         stop_test;
      end
      cyc(1);
   endtask
   task automatic chk_frame(input logic [7:0] act);
      logic [271:0] h;
      h = {PFCG_DMAC, SRC, 16'h8808, 16'h0101, 16'h00ff, 128'h0};
      for (int p = 0; p < 8; p++)
         h[127-16*p -: 16] = act[p] ? PT : 16'h0000;
      for (int i = 0; i < 60; i++)
         chk(32'(i_pfcg_sink.frame[i]), 32'(i < 34 ? h[271-8*i -: 8] : 8'h00));
      ecnt++;
      chk(cnt, ecnt);
   endtask
   task automatic t_off_on;
      cyc(20);
      chk(32'(valid), 32'h0);
      chk(32'(cst), 32'h05);
      ena = 1'b1;
      next_frame;
      chk_frame(8'h01);
      $display("off then on done");
   endtask
   task automatic t_refresh;
      next_frame;
      chk(32'(g), 32'(PT / 2 * QC + 1));
      chk_frame(8'h01);
      $display("refresh done");
   endtask
   task automatic t_early;
      slow = 1'b1;
      vec = 8'h0d;
      next_frame;
      chk(32'(g), 32'(MRI * QC + 1));
      chk_frame(8'h09);
      $display("early refresh done");
   endtask
   task automatic t_release;
      slow = 1'b0;
      vec = 8'h00;
      next_frame;
      chk(32'(g), 32'h2);
      chk_frame(8'h00);
      cyc(300);
      chk(cnt, ecnt);
      $display("release done");
   endtask
   task automatic t_link;
      lps = 1'b1;
      cyc(1);
      lps = 1'b0;
      cyc(1);
      ecnt++;
      chk(cnt, ecnt);
      $display("link pause count done");
   endtask
   // dropping the enable while waiting ends the pause with no release frame
   task automatic t_disable;
      vec = 8'h01;
      next_frame;
      chk(32'(g), 32'h2);
      chk_frame(8'h01);
      ena = 1'b0;
      cyc(300);
      chk(32'(valid), 32'h0);
      chk(cnt, ecnt);
      vec = 8'h00;
      cyc(1);
      ena = 1'b1;
      cyc(20);
      chk(cnt, ecnt);
      $display("disable in wait done");
   endtask
   initial begin
      cyc(2);
      sys_rst = 1'b0;
      t_off_on;
      t_refresh;
      t_early;
      t_release;
      t_link;
      t_disable;
      stop_test;
   end
endmodule
